// *** hdl/adc_clock_consts.svh ***
`ifndef ADC_CLOCK_CONSTS_SVH
`define ADC_CLOCK_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CLOCK_CONFIG_FIRST 8'h00
`define OFS_CLOCK_CONFIG_SECOND 8'h04
`define OFS_CHANNEL_GAIN 8'h08
`define OFS_CHANNEL_POWER 8'h0C
`define OFS_CLOCK_STATUS 8'h10
// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define SRC_SELECT_BIT 7
`define MDIV_LSB 0
`define MDIV_W 3
`define SDIV_LSB 5
`define SDIV_W 3
`define OSR_LSB 0
`define OSR_W 4
`define GAIN_W 3
`define CHANNELS 4
`define GAIN_LEVELS 3'h5
`define RATIO_W 13
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CLOCK_CONFIG_FIRST 8'h00
`define RST_CLOCK_CONFIG_SECOND 8'h00
`define RST_GAIN 3'h0
`define RST_POWER 4'h0
// ----------------------------------------------------------------
// oversampling ratios, modulator clocks per output word
// ----------------------------------------------------------------
`define OSR_R0 13'h1000
`define OSR_R1 13'h07DE
`define OSR_R2 13'h0400
`define OSR_R3 13'h0320
`define OSR_R4 13'h0300
`define OSR_R5 13'h0200
`define OSR_R6 13'h0190
`define OSR_R7 13'h0180
`define OSR_R8 13'h0100
`define OSR_R9 13'h00C8
`define OSR_R10 13'h00C0
`define OSR_R11 13'h0080
`define OSR_R12 13'h0060
`define OSR_R13 13'h0040
`define OSR_R14 13'h0030
`define OSR_R15 13'h0020
`endif

// *** hdl/adc_clock_pkg.sv ***
package adc_clock_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC_INT = 2'b00,
    MODE_SYNC_MASTER = 2'b01,
    MODE_SYNC_SLAVE = 2'b10
  } if_mode_t;
endpackage

// *** hdl/clock_edge_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_clock_consts.svh"
module clock_edge_divider (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic edge_in, // one pulse per source clock edge
  input wire logic [`RATIO_W-1:0] ratio, // source edges per output edge
  output logic clk_out, // divided clock level
  output logic edge_out, // pulse per divided clock edge
  output logic rise_out // pulse per divided clock rising edge
);
  logic [`RATIO_W-1:0] cnt_q;
  logic wrap;

  // counting both edges keeps a 50% duty cycle for odd ratios too
  assign wrap = (cnt_q >= ratio - `RATIO_W'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (edge_in) begin
      cnt_q <= wrap ? '0 : cnt_q + `RATIO_W'(1);
    end
  end

  // output only ever changes from a flop, so it cannot glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out <= 1'b0;
      edge_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      edge_out <= edge_in && wrap;
      rise_out <= edge_in && wrap && !clk_out;
      if (edge_in && wrap) begin
        clk_out <= !clk_out;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_div_wrap: assert property (
    edge_in && wrap |=> edge_out && cnt_q == '0 &&
      clk_out != $past(clk_out))
    else $error("divider did not wrap at its ratio");
  a_div_hold: assert property (
    !edge_in |=> !edge_out && $stable(clk_out))
    else $error("divider moved without an input edge");
endmodule
`default_nettype wire

// *** hdl/adc_clock_source_and_dividers.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_clock_consts.svh"
module adc_clock_source_and_dividers (
  input wire logic hclk, // 20 MHz bus and logic clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // only word transfers used
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  input wire logic ext_master_clock_in, // master clock or crystal
  input wire logic [1:0] interface_mode_pin, // decoded mode strap
  input wire logic sclk_in, // serial clock from host
  output logic sclk_out, // serial clock toward host
  output logic sclk_oe, // serial clock driven when high
  output logic internal_system_clock, // system clock level
  output logic modulator_clock, // modulator clock level
  output logic mod_sample_tick, // modulator sample pulse
  output logic filter_tick, // decimation filter step pulse
  output logic data_ready_strobe, // one pulse per output word
  output logic [3:0] channel_power_en, // channel power enables
  output logic [11:0] channel_gain // 3-bit gain code per channel
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic wr_q;
  logic [7:0] addr_q;
  logic addr_ok;
  logic [7:0] cfg1_q, cfg1_d, cfg2_q, cfg2_d;
  logic [3:0] pwr_q, pwr_d;
  logic [`GAIN_W-1:0] gain_q [`CHANNELS];
  logic [`GAIN_W-1:0] gain_d [`CHANNELS];
  logic [11:0] gain_all_d;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_q;
  logic [5:0] status;

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= addr_ok && hwrite;
      addr_q <= {haddr[7:2], 2'b00};
    end
  end

  // next values feed the read mux, so a read right after a write
  // already sees the written value
  always_comb begin
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    pwr_d = pwr_q;
    if (wr_q && addr_q == `OFS_CLOCK_CONFIG_FIRST) begin
      cfg1_d = hwdata[7:0];
      if (|pwr_q) begin
        // source stays put while channels run
        cfg1_d[`SRC_SELECT_BIT] = cfg1_q[`SRC_SELECT_BIT];
      end
    end
    if (wr_q && addr_q == `OFS_CLOCK_CONFIG_SECOND) begin
      cfg2_d = hwdata[7:0];
    end
    if (wr_q && addr_q == `OFS_CHANNEL_POWER) begin
      pwr_d = hwdata[3:0];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `CHANNELS; ch++) begin : g_gain
      logic [`GAIN_W-1:0] wfield;
      assign wfield = hwdata[ch*`GAIN_W +: `GAIN_W];
      // codes beyond the five legal gains are dropped
      assign gain_d[ch] = (wr_q && addr_q == `OFS_CHANNEL_GAIN &&
                           wfield < `GAIN_LEVELS) ? wfield : gain_q[ch];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gain_q[ch] <= `RST_GAIN;
        end else begin
          gain_q[ch] <= gain_d[ch];
        end
      end
      assign gain_all_d[ch*`GAIN_W +: `GAIN_W] = gain_d[ch];
      assign channel_gain[ch*`GAIN_W +: `GAIN_W] = gain_q[ch];
      a_gain_legal: assert property (
        @(posedge hclk) disable iff (!hresetn) gain_q[ch] < `GAIN_LEVELS)
        else $error("gain code outside the five settings");
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg1_q <= `RST_CLOCK_CONFIG_FIRST;
      cfg2_q <= `RST_CLOCK_CONFIG_SECOND;
      pwr_q <= `RST_POWER;
    end else begin
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      pwr_q <= pwr_d;
    end
  end
  assign channel_power_en = pwr_q;

  always_comb begin
    unique case (haddr[7:0])
      `OFS_CLOCK_CONFIG_FIRST: rd_mux = {24'h0000_00, cfg1_d};
      `OFS_CLOCK_CONFIG_SECOND: rd_mux = {24'h0000_00, cfg2_d};
      `OFS_CHANNEL_GAIN: rd_mux = {20'h0000_0, gain_all_d};
      `OFS_CHANNEL_POWER: rd_mux = {28'h0000_000, pwr_d};
      `OFS_CLOCK_STATUS: rd_mux = {26'h0000_000, status};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  adc_clock_pkg::if_mode_t mode;
  logic sel_sclk;
  logic mclk_prev_q, sclk_prev_q;
  logic mclk_edge, sclk_edge, sys_edge;
  logic mdiv_edge, mod_edge;
  logic internal_system_clock_q;
  logic data_clk;
  logic [`RATIO_W-1:0] osr_ratio;

  always_comb begin
    unique case (interface_mode_pin)
      2'b01: mode = adc_clock_pkg::MODE_SYNC_MASTER;
      2'b10: mode = adc_clock_pkg::MODE_SYNC_SLAVE;
      default: mode = adc_clock_pkg::MODE_ASYNC_INT;
    endcase
  end

  // the serial clock is only honoured in slave mode
  assign sel_sclk = cfg1_q[`SRC_SELECT_BIT] &&
                    mode == adc_clock_pkg::MODE_SYNC_SLAVE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mclk_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= ext_master_clock_in;
      sclk_prev_q <= sclk_in;
    end
  end
  assign mclk_edge = ext_master_clock_in ^ mclk_prev_q;
  assign sclk_edge = sclk_in ^ sclk_prev_q;

  clock_edge_divider u_master_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .edge_in(mclk_edge),
    .ratio(`RATIO_W'(cfg1_q[`MDIV_LSB +: `MDIV_W]) + `RATIO_W'(1)),
    .clk_out(),
    .edge_out(mdiv_edge),
    .rise_out()
  );

  // serial clock bypasses the master divider in slave mode with the source select bit set
  assign sys_edge = sel_sclk ? sclk_edge : mdiv_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_system_clock_q <= 1'b0;
    end else if (sys_edge) begin
      internal_system_clock_q <= !internal_system_clock_q;
    end
  end
  assign internal_system_clock = internal_system_clock_q;

  // master mode hands the system clock to the host
  assign sclk_oe = (mode == adc_clock_pkg::MODE_SYNC_MASTER);
  assign sclk_out = internal_system_clock_q;

  // ----------------------------------------------------------------
  // modulator clock and data rate
  // ----------------------------------------------------------------
  clock_edge_divider u_mod_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .edge_in(sys_edge),
    .ratio(`RATIO_W'(cfg2_q[`SDIV_LSB +: `SDIV_W]) + `RATIO_W'(1)),
    .clk_out(modulator_clock),
    .edge_out(mod_edge),
    .rise_out(mod_sample_tick)
  );
  assign filter_tick = mod_sample_tick;

  always_comb begin
    unique case (cfg2_q[`OSR_LSB +: `OSR_W])
      4'h0: osr_ratio = `OSR_R0;
      4'h1: osr_ratio = `OSR_R1;
      4'h2: osr_ratio = `OSR_R2;
      4'h3: osr_ratio = `OSR_R3;
      4'h4: osr_ratio = `OSR_R4;
      4'h5: osr_ratio = `OSR_R5;
      4'h6: osr_ratio = `OSR_R6;
      4'h7: osr_ratio = `OSR_R7;
      4'h8: osr_ratio = `OSR_R8;
      4'h9: osr_ratio = `OSR_R9;
      4'hA: osr_ratio = `OSR_R10;
      4'hB: osr_ratio = `OSR_R11;
      4'hC: osr_ratio = `OSR_R12;
      4'hD: osr_ratio = `OSR_R13;
      4'hE: osr_ratio = `OSR_R14;
      4'hF: osr_ratio = `OSR_R15;
    endcase
  end

  // counting modulator edges by the ratio gives one word per ratio periods
  clock_edge_divider u_osr_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .edge_in(mod_edge),
    .ratio(osr_ratio),
    .clk_out(data_clk),
    .edge_out(),
    .rise_out(data_ready_strobe)
  );

  assign status = {data_clk, modulator_clock, internal_system_clock_q, mode, sel_sclk};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_sys_step;
    sys_edge ##1 (internal_system_clock != $past(internal_system_clock));
  endsequence
  sequence s_mod_step;
    $changed(modulator_clock) ##0 $past(sys_edge);
  endsequence

  a_internal_system_clock_follows: assert property (sys_edge |-> s_sys_step)
    else $error("system clock missed a source edge");
  a_slave_only: assert property (
    sel_sclk |-> mode == adc_clock_pkg::MODE_SYNC_SLAVE)
    else $error("serial clock used outside slave mode");
  a_mod_from_sys: assert property (
    $changed(modulator_clock) |-> s_mod_step)
    else $error("modulator clock moved without a system edge");
  a_tick_on_rise: assert property (
    mod_sample_tick |-> modulator_clock && $past(!modulator_clock) &&
      filter_tick)
    else $error("sample tick not on modulator rising edge");
  a_master_path: assert property (
    mode != adc_clock_pkg::MODE_SYNC_SLAVE |-> sys_edge == mdiv_edge)
    else $error("serial clock reached system clock");
  a_src_bit_off: assert property (
    !cfg1_q[`SRC_SELECT_BIT] |-> !sel_sclk)
    else $error("serial source taken with select bit low");
  a_src_locked: assert property (
    (|pwr_q) |=> $stable(cfg1_q[`SRC_SELECT_BIT]))
    else $error("source changed while channels powered");
  a_osr_table: assert property (
    cfg2_q[`OSR_LSB +: `OSR_W] == 4'hF |-> osr_ratio == `RATIO_W'(32))
    else $error("lowest ratio not 32");
  a_data_ready_strobe_cause: assert property (
    data_ready_strobe |-> $past(mod_edge) && !$past(data_ready_strobe))
    else $error("data ready without a modulator edge");
  a_sclk_drive: assert property (
    mode == adc_clock_pkg::MODE_SYNC_MASTER |-> sclk_oe &&
      sclk_out == internal_system_clock)
    else $error("serial clock not driven in master mode");
endmodule
`default_nettype wire

// *** testbench/host_sclk_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host side: free-running serial clock, one level change per two hclk
// ----------------------------------------------------------------
module host_sclk_model (
  input wire logic hclk, // bench clock
  input wire logic run, // host clock running
  output logic sclk // serial clock toward the device
);
  logic ph_q = 1'b0;
  logic sclk_q = 1'b0;
  // runs without gaps while enabled, as the slave source needs
  always_ff @(posedge hclk) begin
    if (run) begin
      ph_q <= ~ph_q;
      if (ph_q) begin
        sclk_q <= ~sclk_q;
      end
    end
  end
  assign sclk = sclk_q;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_clock_consts.svh"
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, sclk_run;
  logic ext_clk = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic sclk_in, sclk_out, sclk_oe, sys_clk, mod_clk, tick, filt, strobe;
  logic [3:0] power;
  logic [11:0] gain;
  logic ext_run;
  logic sys_p = 1'b0;
  logic mod_p = 1'b0;
  logic [31:0] sys_cnt = '0, mod_cnt = '0, tick_cnt = '0, filt_cnt = '0;
  logic [31:0] rd;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [12:0] osr_tab [16] = '{`OSR_R0, `OSR_R1, `OSR_R2, `OSR_R3,
    `OSR_R4, `OSR_R5, `OSR_R6, `OSR_R7, `OSR_R8, `OSR_R9, `OSR_R10,
    `OSR_R11, `OSR_R12, `OSR_R13, `OSR_R14, `OSR_R15};
  adc_clock_source_and_dividers dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .ext_master_clock_in(ext_clk),
    .interface_mode_pin(mode), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .internal_system_clock(sys_clk),
    .modulator_clock(mod_clk), .mod_sample_tick(tick), .filter_tick(filt),
    .data_ready_strobe(strobe), .channel_power_en(power),
    .channel_gain(gain));
  host_sclk_model host (.hclk(hclk), .run(sclk_run), .sclk(sclk_in));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // free-running event counters, read as differences to avoid races
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (ext_run) ext_clk <= ~ext_clk;
    sys_p <= sys_clk;
    mod_p <= mod_clk;
    if (sys_p !== sys_clk) sys_cnt <= sys_cnt + 1;
    if (mod_p !== mod_clk) mod_cnt <= mod_cnt + 1;
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (filt === 1'b1) filt_cnt <= filt_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic near(input logic [31:0] got, input logic [31:0] exp);
    chk(32'(got + 1 >= exp && got <= exp + 1), 32'h0000_0001);
  endtask
  // ----------------------------------------------------------------
  // bus cycles: hold each phase until hready is sampled high
  // ----------------------------------------------------------------
  task automatic ahb(input logic [31:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0000_0000;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d, rd);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0000_0000, rd);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic test_reset;
    for (int a = 0; a <= 'h14; a += 4) rchk(a, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic test_sys_div;
    logic [31:0] s;
    ext_run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_CLOCK_CONFIG_FIRST, c);
      repeat (20) @(posedge hclk);
      s = sys_cnt;
      repeat (16 * (c + 1)) @(posedge hclk);
      near(sys_cnt - s, 16);
    end
    $display("test system divider done");
  endtask
  task automatic test_mod_div;
    logic [31:0] m, t, f;
    wr(`OFS_CLOCK_CONFIG_FIRST, 0);
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_CLOCK_CONFIG_SECOND, (c << 5) | 15);
      repeat (40) @(posedge hclk);
      m = mod_cnt;
      t = tick_cnt;
      f = filt_cnt;
      repeat (32 * (c + 1)) @(posedge hclk);
      near(mod_cnt - m, 32);
      near(tick_cnt - t, 16);
      near(filt_cnt - f, 16);
    end
    $display("test modulator divider done");
  endtask
  task automatic test_osr;
    logic [31:0] t;
    for (int c = 0; c < 16; c++) begin
      wr(`OFS_CLOCK_CONFIG_SECOND, c);
      do @(posedge hclk); while (strobe !== 1'b1);
      t = tick_cnt;
      do @(posedge hclk); while (strobe !== 1'b1);
      chk(tick_cnt - t, {19'h0, osr_tab[c]});
    end
    $display("test oversampling done");
  endtask
  task automatic test_source;
    logic [31:0] s;
    ext_run <= 1'b0;
    sclk_run <= 1'b1;
    wr(`OFS_CLOCK_CONFIG_FIRST, 32'h0000_0080);
    for (int md = 0; md < 4; md++) begin
      mode <= 2'(md);
      repeat (10) @(posedge hclk);
      chk({31'h0, sclk_oe}, md == 1);
      if (md == 1) chk({31'h0, sclk_out}, {31'h0, sys_clk});
      s = sys_cnt;
      repeat (32) @(posedge hclk);
      if (md == 2) near(sys_cnt - s, 16);
      else chk(sys_cnt - s, 0);
      ahb(`OFS_CLOCK_STATUS, 1'b0, 32'h0000_0000, rd);
      chk(rd[0], md == 2);
      chk(rd[2:1], (md == 3) ? 0 : md);
    end
    sclk_run <= 1'b0;
    ext_run <= 1'b1;
    wr(`OFS_CLOCK_CONFIG_FIRST, 0);
    repeat (10) @(posedge hclk);
    s = sys_cnt;
    repeat (32) @(posedge hclk);
    near(sys_cnt - s, 32);
    mode <= 2'h0;
    $display("test clock source done");
  endtask
  task automatic test_lock_gain;
    wr(`OFS_CHANNEL_POWER, 32'h0000_000F);
    // the enables change at the edge that ends the data phase
    @(posedge hclk);
    chk({28'h0, power}, 32'h0000_000F);
    wr(`OFS_CLOCK_CONFIG_FIRST, 32'h0000_0083);
    rchk(`OFS_CLOCK_CONFIG_FIRST, 32'h0000_0003);
    wr(`OFS_CHANNEL_POWER, 0);
    wr(`OFS_CLOCK_CONFIG_FIRST, 32'h0000_0083);
    rchk(`OFS_CLOCK_CONFIG_FIRST, 32'h0000_0083);
    wr(`OFS_CLOCK_CONFIG_SECOND, 32'h0000_00EF);
    rchk(`OFS_CLOCK_CONFIG_SECOND, 32'h0000_00EF);
    for (int g = 0; g < 6; g++) begin
      wr(`OFS_CHANNEL_GAIN, {4{3'(g)}});
      rchk(`OFS_CHANNEL_GAIN, {4{3'(g < 5 ? g : 4)}});
      chk({20'h0, gain}, {4{3'(g < 5 ? g : 4)}});
    end
    $display("test lock and gain done");
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    mode = 2'h0;
    ext_run = 1'b0;
    sclk_run = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_sys_div();
    test_mod_div();
    test_osr();
    test_source();
    test_lock_gain();
    finish_test();
  end
  // hang guard sized well above the longest oversampling wait
  initial begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
